// [hdl/rsa_top.v]
// Purpose: speed raise/lower memory and keypad override of the drive
// Assumes: pins are asynchronous; terminal_freq is on the aclk domain
// Notes: registers reached over AXI4-Lite; unmapped addresses give SLVERR
`timescale 1ns/1ns
`default_nettype none
`include "rsa_regs.vh"
module rsa_top #(
   parameter TICK_CYCLES = `RSA_TICK_CYCLES
) (
   input wire aclk,
   input wire aresetn,
   input wire [7:0] s_axi_awaddr,
   input wire [2:0] s_axi_awprot,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire [2:0] s_axi_arprot,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire speed_raise_input,
   input wire speed_lower_input,
   input wire adjustment_clear_input,
   input wire keypad_override_input,
   input wire jog_function,
   input wire terminal_run,
   input wire [15:0] terminal_freq,
   output reg motor_run,
   output reg [15:0] freq_setpoint
);
   localparam ST_IDLE = 2'd0;
   localparam ST_RUN = 2'd1;
   localparam ST_STOP = 2'd2;

   function [15:0] merge16;
      input [15:0] old;
      input [31:0] data;
      input [3:0] strb;
      begin
         merge16 = old;
         if (strb[0]) begin
            merge16[7:0] = data[7:0];
         end
         if (strb[1]) begin
            merge16[15:8] = data[15:8];
         end
      end
   endfunction

   function mapped;
      input [7:0] addr;
      begin
         mapped = (addr[1:0] == 2'b00) && (addr <= `RSA_OFS_FREQ);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   wire [4:0] pin_raw;
   wire [4:0] pin_sync;
   wire raise_s;
   wire lower_s;
   wire clear_s;
   wire ovr_s;
   wire jog_s;
   reg trun_meta;
   reg trun_s;

   assign pin_raw = {jog_function, keypad_override_input, adjustment_clear_input,
                     speed_lower_input, speed_raise_input};
   genvar gi;
   generate
      for (gi = 0; gi < `RSA_PIN_N; gi = gi + 1) begin : g_sync
         // One pair of flops per pin, so each bit has a single driver
         reg meta;
         reg sync;
         always @(posedge aclk) begin
            if (!aresetn) begin
               meta <= 1'b0;
               sync <= 1'b0;
            end else begin
               meta <= pin_raw[gi];
               sync <= meta;
            end
         end
         assign pin_sync[gi] = sync;
      end
   endgenerate
   assign raise_s = pin_sync[0];
   assign lower_s = pin_sync[1];
   assign clear_s = pin_sync[2];
   assign ovr_s = pin_sync[3];
   assign jog_s = pin_sync[4];

   always @(posedge aclk) begin
      if (!aresetn) begin
         trun_meta <= 1'b0;
         trun_s <= 1'b0;
      end else begin
         trun_meta <= terminal_run;
         trun_s <= trun_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write path
   reg aw_held;
   reg w_held;
   reg [7:0] aw_addr;
   reg [31:0] w_data;
   reg [3:0] w_strb;
   wire wr_go;

   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready = !w_held && !s_axi_bvalid;
   assign wr_go = aw_held && w_held && !s_axi_bvalid;

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RSA_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= mapped(aw_addr) ? `RSA_RESP_OKAY : `RSA_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Configuration registers
   reg retain;
   reg motor2;
   reg [1:0] fsrc_cfg;
   reg [1:0] rsrc_cfg;
   reg [15:0] max_f;
   reg [15:0] kfreq;
   reg [15:0] first_accel_time;
   reg [15:0] first_decel_time;
   reg [15:0] acc2;
   reg [15:0] dec2;
   wire wr_ctrl;
   wire wr_keycmd;
   wire wr_nv;

   assign wr_ctrl = wr_go && aw_addr == `RSA_OFS_CTRL && w_strb[0];
   assign wr_keycmd = wr_go && aw_addr == `RSA_OFS_KEYCMD && w_strb[0];
   assign wr_nv = wr_go && aw_addr == `RSA_OFS_NVFREQ;

   always @(posedge aclk) begin
      if (!aresetn) begin
         retain <= 1'b0;
         motor2 <= 1'b0;
         fsrc_cfg <= `RSA_RST_FSRC;
         rsrc_cfg <= `RSA_RST_RSRC;
         max_f <= `RSA_RST_MAXF;
         kfreq <= 16'h0000;
         first_accel_time <= `RSA_RST_TIME;
         first_decel_time <= `RSA_RST_TIME;
         acc2 <= `RSA_RST_TIME;
         dec2 <= `RSA_RST_TIME;
      end else if (wr_go) begin
         if (wr_ctrl) begin
            retain <= w_data[`RSA_CTRL_RETAIN];
            motor2 <= w_data[`RSA_CTRL_MOTOR2];
         end
         if (aw_addr == `RSA_OFS_FSRC && w_strb[0]) begin
            fsrc_cfg <= w_data[1:0];
         end
         if (aw_addr == `RSA_OFS_RSRC && w_strb[0]) begin
            rsrc_cfg <= w_data[1:0];
         end
         if (aw_addr == `RSA_OFS_MAXF) begin
            max_f <= merge16(max_f, w_data, w_strb);
         end
         if (aw_addr == `RSA_OFS_KFREQ) begin
            kfreq <= merge16(kfreq, w_data, w_strb);
         end
         if (aw_addr == `RSA_OFS_FIRST_ACCEL_TIME) begin
            first_accel_time <= merge16(first_accel_time, w_data, w_strb);
         end
         if (aw_addr == `RSA_OFS_FIRST_DECEL_TIME) begin
            first_decel_time <= merge16(first_decel_time, w_data, w_strb);
         end
         if (aw_addr == `RSA_OFS_ACC2) begin
            acc2 <= merge16(acc2, w_data, w_strb);
         end
         if (aw_addr == `RSA_OFS_DEC2) begin
            dec2 <= merge16(dec2, w_data, w_strb);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Source selection and run control
   reg ovr_applied;
   reg [1:0] run_state;
   reg kp_run;
   wire [1:0] fsrc_eff;
   wire [1:0] rsrc_eff;
   wire run_cmd;
   wire kp_start;
   wire kp_stop;
   wire ovr_change;

   assign fsrc_eff = ovr_applied ? `RSA_SRC_KEYPAD : fsrc_cfg;
   assign rsrc_eff = ovr_applied ? `RSA_SRC_KEYPAD : rsrc_cfg;
   assign kp_start = wr_keycmd && w_data[`RSA_KEY_RUN];
   assign kp_stop = wr_keycmd && w_data[`RSA_KEY_STOP];
   assign run_cmd = (rsrc_eff == `RSA_SRC_KEYPAD) ? kp_run : trun_s;
   assign ovr_change = ovr_s != ovr_applied;

   always @(posedge aclk) begin
      if (!aresetn) begin
         run_state <= ST_IDLE;
         ovr_applied <= 1'b0;
         kp_run <= 1'b0;
         motor_run <= 1'b0;
      end else begin
         if (kp_stop) begin
            kp_run <= 1'b0;
         end else if (kp_start) begin
            kp_run <= 1'b1;
         end
         case (run_state)
            ST_IDLE: begin
               ovr_applied <= ovr_s;
               if (!ovr_change && run_cmd) begin
                  run_state <= ST_RUN;
                  motor_run <= 1'b1;
               end
            end
            ST_RUN: begin
               if (ovr_applied == 1'b0 && ovr_s && kp_start) begin
                  run_state <= ST_STOP;
                  motor_run <= 1'b0;
                  kp_run <= 1'b0;
               end else if (ovr_change) begin
                  run_state <= ST_STOP;
                  motor_run <= 1'b0;
                  kp_run <= 1'b0;
               end else if (!run_cmd) begin
                  run_state <= ST_IDLE;
                  motor_run <= 1'b0;
               end
            end
            ST_STOP: begin
               ovr_applied <= ovr_s;
               if (!run_cmd && !kp_start) begin
                  run_state <= ST_IDLE;
               end
            end
            default: begin
               run_state <= ST_IDLE;
               motor_run <= 1'b0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Raise/lower memory
   reg [16:0] tick_cnt;
   reg tick;
   reg adj_used;
   reg boot_load;
   reg [15:0] nv_freq;
   wire adj_ok;
   wire up_go;
   wire dn_go;
   wire [15:0] rate;
   wire load;
   wire [15:0] load_val;
   wire [15:0] adj_freq;

   assign adj_ok = (fsrc_eff == `RSA_SRC_KEYPAD) && !jog_s;
   assign up_go = adj_ok && raise_s && !clear_s;
   assign dn_go = adj_ok && lower_s && !clear_s;
   assign rate = up_go ? (motor2 ? acc2 : first_accel_time) : (motor2 ? dec2 : first_decel_time);
   assign load = boot_load || clear_s || (!adj_used && !up_go && !dn_go);
   assign load_val = (boot_load && retain) ? nv_freq : kfreq;

   always @(posedge aclk) begin
      if (!aresetn) begin
         tick_cnt <= 17'h00000;
         tick <= 1'b0;
      end else if (tick_cnt == TICK_CYCLES[16:0] - 17'h00001) begin
         tick_cnt <= 17'h00000;
         tick <= 1'b1;
      end else begin
         tick_cnt <= tick_cnt + 17'h00001;
         tick <= 1'b0;
      end
   end

   rsa_ramp u_ramp (
      .aclk(aclk),
      .aresetn(aresetn),
      .tick(tick),
      .up(up_go),
      .down(dn_go),
      .time_ms(rate),
      .max_f(max_f),
      .load(load),
      .load_val(load_val),
      .freq(adj_freq)
   );

   always @(posedge aclk) begin
      if (!aresetn) begin
         boot_load <= 1'b1;
         adj_used <= 1'b0;
         nv_freq <= 16'h0000;
      end else begin
         boot_load <= 1'b0;
         if (clear_s) begin
            adj_used <= 1'b0;
            nv_freq <= kfreq;
         end else if (wr_nv) begin
            nv_freq <= merge16(nv_freq, w_data, w_strb);
         end else if (retain && adj_used) begin
            nv_freq <= adj_freq;
         end
         if (boot_load && retain) begin
            adj_used <= 1'b1;
         end else if (!clear_s && (up_go || dn_go)) begin
            adj_used <= 1'b1;
         end
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         freq_setpoint <= 16'h0000;
      end else if (fsrc_eff == `RSA_SRC_KEYPAD) begin
         freq_setpoint <= adj_freq;
      end else begin
         freq_setpoint <= terminal_freq;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite read path
   reg [31:0] rd_mux;

   assign s_axi_arready = !s_axi_rvalid;

   always @* begin
      rd_mux = 32'h00000000;
      case (s_axi_araddr)
         `RSA_OFS_CTRL: rd_mux = {30'h00000000, motor2, retain};
         `RSA_OFS_FSRC: rd_mux = {30'h00000000, fsrc_cfg};
         `RSA_OFS_RSRC: rd_mux = {30'h00000000, rsrc_cfg};
         `RSA_OFS_MAXF: rd_mux = {16'h0000, max_f};
         `RSA_OFS_KFREQ: rd_mux = {16'h0000, kfreq};
         `RSA_OFS_FIRST_ACCEL_TIME: rd_mux = {16'h0000, first_accel_time};
         `RSA_OFS_FIRST_DECEL_TIME: rd_mux = {16'h0000, first_decel_time};
         `RSA_OFS_ACC2: rd_mux = {16'h0000, acc2};
         `RSA_OFS_DEC2: rd_mux = {16'h0000, dec2};
         `RSA_OFS_KEYCMD: rd_mux = {31'h00000000, kp_run};
         `RSA_OFS_NVFREQ: rd_mux = {16'h0000, nv_freq};
         `RSA_OFS_STATUS: rd_mux = {25'h0000000, adj_used, rsrc_eff, fsrc_eff,
                                    ovr_applied, motor_run};
         `RSA_OFS_FREQ: rd_mux = {16'h0000, adj_freq};
         default: rd_mux = 32'h00000000;
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `RSA_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_mux;
         s_axi_rresp <= mapped(s_axi_araddr) ? `RSA_RESP_OKAY : `RSA_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule // rsa_top
`default_nettype wire

// [hdl/rsa_regs.vh]
// Purpose: constants for the remote speed adjust and keypad override block
// Assumes: 100 MHz aclk, AXI4-Lite byte addresses, frequencies in 0.01 Hz
// Notes: ramp times are in ms for a sweep from 0 Hz to maximum frequency
`ifndef RSA_REGS_VH
`define RSA_REGS_VH
`define RSA_ADDR_W 8
`define RSA_OFS_CTRL 8'h00
`define RSA_OFS_FSRC 8'h04
`define RSA_OFS_RSRC 8'h08
`define RSA_OFS_MAXF 8'h0C
`define RSA_OFS_KFREQ 8'h10
`define RSA_OFS_FIRST_ACCEL_TIME 8'h14
`define RSA_OFS_FIRST_DECEL_TIME 8'h18
`define RSA_OFS_ACC2 8'h1C
`define RSA_OFS_DEC2 8'h20
`define RSA_OFS_KEYCMD 8'h24
`define RSA_OFS_NVFREQ 8'h28
`define RSA_OFS_STATUS 8'h2C
`define RSA_OFS_FREQ 8'h30
`define RSA_CTRL_RETAIN 0
`define RSA_CTRL_MOTOR2 1
`define RSA_KEY_RUN 0
`define RSA_KEY_STOP 1
`define RSA_ST_RUN 0
`define RSA_ST_OVR 1
`define RSA_ST_FSRC 3:2
`define RSA_ST_RSRC 5:4
`define RSA_ST_ADJ 6
`define RSA_SRC_KEYPAD 2'h2
`define RSA_RST_FSRC 2'h1
`define RSA_RST_RSRC 2'h1
`define RSA_RST_MAXF 16'h1388
`define RSA_RST_TIME 16'h2710
`define RSA_RESP_OKAY 2'h0
`define RSA_RESP_SLVERR 2'h2
`define RSA_CLK_MHZ 100
`define RSA_TICK_US 1000
`define RSA_TICK_CYCLES (`RSA_TICK_US * `RSA_CLK_MHZ)
`define RSA_PIN_N 5
`endif

// [hdl/rsa_ramp.v]
// Purpose: ramps a frequency up or down at a rate set by a sweep time
// Assumes: tick pulses once per ms; time_ms is the 0-to-max sweep time
// Notes: a zero time jumps straight to the limit
`timescale 1ns/1ns
`default_nettype none
module rsa_ramp (
   input wire aclk,
   input wire aresetn,
   input wire tick,
   input wire up,
   input wire down,
   input wire [15:0] time_ms,
   input wire [15:0] max_f,
   input wire load,
   input wire [15:0] load_val,
   output reg [15:0] freq
);
   reg [31:0] acc;
   reg [31:0] next_acc;
   reg [15:0] next_freq;
   wire moving;
   wire [31:0] acc_in;

   assign moving = up ^ down;
   assign acc_in = tick ? acc + {16'h0000, max_f} : acc;

   always @* begin
      next_acc = 32'h00000000;
      next_freq = freq;
      if (load) begin
         next_freq = (load_val > max_f) ? max_f : load_val;
      end else if (moving) begin
         next_acc = acc_in;
         if (time_ms == 16'h0000) begin
            next_freq = up ? max_f : 16'h0000;
         end else if (acc_in >= {16'h0000, time_ms}) begin
            next_acc = acc_in - {16'h0000, time_ms};
            if (up && freq < max_f) begin
               next_freq = freq + 16'h0001;
            end else if (down && freq != 16'h0000) begin
               next_freq = freq - 16'h0001;
            end
         end
      end
      if (next_freq > max_f) begin
         next_freq = max_f;
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         acc <= 32'h00000000;
         freq <= 16'h0000;
      end else begin
         acc <= next_acc;
         freq <= next_freq;
      end
   end
endmodule // rsa_ramp
`default_nettype wire

// [verification/rsa_pins.sv]
// Purpose: external raise and lower contacts driving rsa_top
// Assumes: want pulses for one aclk cycle to start an activation
// Notes: MIN_ON is counted in aclk cycles
`timescale 1ns/1ns
`default_nettype none
module rsa_pins #(
   parameter int MIN_ON = 500
) (
   input wire logic aclk,
   input wire logic [1:0] want,
   output logic speed_raise_input,
   output logic speed_lower_input
);
   int left [2];
   initial begin
      left = '{0, 0};
      speed_raise_input = 1'b0;
      speed_lower_input = 1'b0;
   end
   // Contact stays closed for at least MIN_ON cycles
   always @(posedge aclk) begin
      for (int i = 0; i < 2; i++) begin
         if (want[i]) left[i] <= MIN_ON;
         else if (left[i] > 0) left[i] <= left[i] - 1;
      end
      speed_raise_input <= want[0] || left[0] > 1;
      speed_lower_input <= want[1] || left[1] > 1;
   end
endmodule // rsa_pins
`default_nettype wire

// [verification/rsa_top_chk.sv]
// Purpose: port-level checks of rsa_top
// Assumes: one aclk domain, synchronous active-low reset
// Notes: bound into every rsa_top
`timescale 1ns/1ns
`default_nettype none
module rsa_top_chk #(
   parameter TICK_CYCLES = 10
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic speed_raise_input,
   input wire logic speed_lower_input,
   input wire logic adjustment_clear_input,
   input wire logic keypad_override_input,
   input wire logic terminal_run,
   input wire logic [15:0] terminal_freq,
   input wire logic motor_run,
   input wire logic [15:0] freq_setpoint
);
   default clocking dcb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_wtake;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_quiet;
      (!speed_raise_input && !speed_lower_input && !adjustment_clear_input && !s_axi_awvalid
         && $stable(terminal_freq) && $stable(keypad_override_input)
         && $stable(terminal_run))[*8];
   endsequence
   sequence s_both;
      (speed_raise_input && speed_lower_input && !adjustment_clear_input && !s_axi_awvalid)[*8];
   endsequence
   AST_BV: assert property (s_wtake |-> ##2 s_axi_bvalid)
      else $error("write answer late");
   AST_AWR: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken during answer");
   AST_RV: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   AST_ARR: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken during answer");
   AST_RBAD: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h30
      |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
   AST_HOLD: assert property (s_quiet |-> $stable(freq_setpoint))
      else $error("setpoint moved with inputs released");
   AST_BOTH: assert property (s_both |-> $stable(freq_setpoint))
      else $error("setpoint moved with both inputs");
   AST_UP: assert property (
      freq_setpoint == $past(freq_setpoint) + 16'h1 && $stable(terminal_freq)
      |-> $past(speed_raise_input, 2) || $past(speed_raise_input, 3)
         || $past(speed_raise_input, 4))
      else $error("step up without raise");
   AST_DOWN: assert property (
      freq_setpoint == $past(freq_setpoint) - 16'h1 && $stable(terminal_freq)
      |-> $past(speed_lower_input, 2) || $past(speed_lower_input, 3)
         || $past(speed_lower_input, 4))
      else $error("step down without lower");
   AST_STOP: assert property (
      motor_run && $changed(keypad_override_input) |-> ##[1:5] !motor_run)
      else $error("no stop on override change");
endmodule // rsa_top_chk
bind rsa_top rsa_top_chk #(.TICK_CYCLES(TICK_CYCLES)) i_rsa_top_chk (.*);
`default_nettype wire

// [verification/rsa_top_tb_top.sv]
// Purpose: self-checking bench of rsa_top
// Assumes: TICK_CYCLES shortened to 10, so 1 ms becomes 10 cycles
// Notes: raise and lower come from rsa_pins
`timescale 1ns/1ns
`default_nettype none
`include "rsa_regs.vh"
module rsa_top_tb_top;
   localparam int TICK = 10;
   logic aclk, aresetn;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [2:0] s_axi_awprot, s_axi_arprot;
   logic [31:0] s_axi_wdata, s_axi_rdata, d, f;
   logic [3:0] s_axi_wstrb;
   logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, motor_run;
   logic [1:0] s_axi_bresp, s_axi_rresp, want, r;
   logic [15:0] freq_setpoint, terminal_freq;
   logic speed_raise_input, speed_lower_input, adjustment_clear_input;
   logic keypad_override_input, jog_function, terminal_run;
   logic [41:0] rows [13];
   int n_mismatch, comparisons;
   rsa_top #(.TICK_CYCLES(TICK)) i_rsa_top (.*);
   rsa_pins #(.MIN_ON(50 * TICK)) i_rsa_pins (.*);
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic chr(input logic [31:0] seen, input logic [31:0] lo, input logic [31:0] hi);
      chk({31'h0, seen >= lo && seen <= hi}, 32'h1);
   endtask
   task automatic report_and_stop;
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task automatic axw(input logic [7:0] a, input logic [31:0] v);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) begin
            r = s_axi_bresp;
            s_axi_bready <= 1'b0;
            break;
         end
      end
   endtask
   task automatic axr(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) begin
            d = s_axi_rdata;
            r = s_axi_rresp;
            s_axi_rready <= 1'b0;
            break;
         end
      end
   endtask
   // One activation of the contacts, then read back the adjusted value
   task automatic pulse(input logic [1:0] v);
      @(posedge aclk);
      want <= v;
      @(posedge aclk);
      want <= 2'h0;
      wt(600);
      axr(`RSA_OFS_FREQ);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Whole run is near 5800 cycles
   initial begin
      #300000;
      n_mismatch++;
      report_and_stop();
   end
   initial begin
      {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata, s_axi_awvalid,
         s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, want, adjustment_clear_input,
         keypad_override_input, jog_function, terminal_run, n_mismatch, comparisons} = '0;
      s_axi_wstrb = 4'hF;
      terminal_freq = 16'hBB8;
      aresetn = 1'b0;
      rows = '{{8'h00, 32'h0, 2'h0}, {8'h04, 32'h1, 2'h0}, {8'h08, 32'h1, 2'h0},
         {8'h0C, 32'h1388, 2'h0}, {8'h10, 32'h0, 2'h0}, {8'h14, 32'h2710, 2'h0},
         {8'h18, 32'h2710, 2'h0}, {8'h1C, 32'h2710, 2'h0}, {8'h20, 32'h2710, 2'h0},
         {8'h2C, 32'h14, 2'h0}, {8'h30, 32'h0, 2'h0}, {8'h34, 32'h0, 2'h2}, {8'h02, 32'h0, 2'h2}};
      wt(4);
      chk({15'h0, motor_run, freq_setpoint}, 32'h0);
      aresetn <= 1'b1;
      wt(2);
      chk({15'h0, motor_run, freq_setpoint}, 32'hBB8);
      for (int i = 0; i < 13; i++) begin
         axr(rows[i][41:34]);
         chk(d, rows[i][33:2]);
         chk({30'h0, r}, {30'h0, rows[i][1:0]});
      end
      axw(8'h34, 32'h1);
      chk({30'h0, r}, 32'h2);
      axw(`RSA_OFS_MAXF, 32'h64);
      axw(`RSA_OFS_FIRST_ACCEL_TIME, 32'h64);
      axw(`RSA_OFS_FIRST_DECEL_TIME, 32'h64);
      axw(`RSA_OFS_ACC2, 32'h19);
      axw(`RSA_OFS_DEC2, 32'h19);
      axw(`RSA_OFS_FSRC, 32'h2);
      axw(`RSA_OFS_KFREQ, 32'h14);
      wt(4);
      chk({16'h0, freq_setpoint}, 32'h14);
      pulse(2'h1);
      chr(d, 32'h42, 32'h4A);
      f = d;
      wt(200);
      axr(`RSA_OFS_FREQ);
      chk(d, f);
      pulse(2'h2);
      chr(d, 32'h10, 32'h18);
      f = d;
      jog_function <= 1'b1;
      pulse(2'h1);
      chk(d, f);
      jog_function <= 1'b0;
      pulse(2'h3);
      chk(d, f);
      axw(`RSA_OFS_CTRL, 32'h2);
      pulse(2'h1);
      chk(d, 32'h64);
      pulse(2'h2);
      chk(d, 32'h0);
      adjustment_clear_input <= 1'b1;
      wt(6);
      adjustment_clear_input <= 1'b0;
      wt(6);
      axr(`RSA_OFS_FREQ);
      chk(d, 32'h14);
      axw(`RSA_OFS_CTRL, 32'h3);
      pulse(2'h2);
      axr(`RSA_OFS_NVFREQ);
      chk(d, 32'h0);
      axw(`RSA_OFS_CTRL, 32'h2);
      pulse(2'h1);
      aresetn <= 1'b0;
      wt(4);
      aresetn <= 1'b1;
      wt(2);
      axr(`RSA_OFS_FREQ);
      chk(d, 32'h0);
      axw(`RSA_OFS_KFREQ, 32'h1E);
      pulse(2'h1);
      chk(d, 32'h1E);
      chk({16'h0, freq_setpoint}, 32'hBB8);
      keypad_override_input <= 1'b1;
      wt(6);
      axr(`RSA_OFS_STATUS);
      chk({28'h0, d[5:2]}, 32'hA);
      chk({16'h0, freq_setpoint}, 32'h1E);
      axw(`RSA_OFS_KEYCMD, 32'h1);
      wt(4);
      chk({31'h0, motor_run}, 32'h1);
      axw(`RSA_OFS_KEYCMD, 32'h2);
      wt(4);
      chk({31'h0, motor_run}, 32'h0);
      keypad_override_input <= 1'b0;
      wt(6);
      axr(`RSA_OFS_STATUS);
      chk({28'h0, d[5:2]}, 32'h5);
      terminal_run <= 1'b1;
      wt(6);
      chk({31'h0, motor_run}, 32'h1);
      keypad_override_input <= 1'b1;
      axw(`RSA_OFS_KEYCMD, 32'h1);
      wt(6);
      chk({31'h0, motor_run}, 32'h0);
      terminal_run <= 1'b0;
      wt(6);
      axr(`RSA_OFS_STATUS);
      chk({28'h0, d[5:2]}, 32'hA);
      chk({31'h0, motor_run}, 32'h0);
      axw(`RSA_OFS_KEYCMD, 32'h1);
      wt(4);
      chk({31'h0, motor_run}, 32'h1);
      report_and_stop();
   end
endmodule // rsa_top_tb_top
`default_nettype wire
